// ---- htgc_csrs.sv ----
`timescale 1ns/1ps
module htgc_csrs #(
    parameter int MID_W = 7
) (
    // Clock, reset, enable
    input  wire logic                   mclk,
    input  wire logic                   reset,
    input  wire logic                   clk_en,
    // AHB-Lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic      [1:0]             hresp,
    // Hart side
    input  wire logic [63:0]            time_value,
    input  wire logic [2:0]             priv_mode,
    input  wire htgc_pkg::htgc_trap_s   trap_in,
    output logic                        gatp_active_q,
    output logic                        gatp_bare_q,
    output logic      [MID_W-1:0]       machine_identifier_q,
    output logic      [htgc_pkg::GATP_PPN_W-1:0] root_page_number_q,
    output logic                        illegal_access_q
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [63:0] time_offset_q;
    logic [31:0] trap_value_q;
    logic [31:0] trap_inst_q;
    logic        scheme_q;
    logic        tvm_q;
    logic        hu_q;
    logic        ap_valid_q;
    logic        ap_write_q;
    logic [7:0]  ap_addr_q;
    logic        wr_ok;
    logic        gatp_hit;
    logic [htgc_pkg::MID_W_MAX-1:0] mid_read;

    // Only NONSEQ single transfers are decoded; hsize is not checked
    wire ap_take = clk_en && hsel && hready && (htrans == htgc_pkg::HTRANS_NONSEQ);

    // Guest address shifted right two, bits 33:2
    function automatic logic [31:0] gpa_shift(input logic [htgc_pkg::GPA_W-1:0] a);
        gpa_shift = a[htgc_pkg::GPA_W-1:htgc_pkg::GPA_SHIFT];
    endfunction

    // Translation control accessed from supervisor mode while trapped
    function automatic logic gatp_blocked(input logic [7:0] a, input logic [2:0] p,
                                          input logic t);
        gatp_blocked = (a == htgc_pkg::OFF_GATP) && t
                       && (p == 3'(htgc_pkg::HTGC_PRIV_S));
    endfunction

    // ------------------------------------------------------------------
    // AHB address phase capture
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q  <= 8'h00;
        end else if (clk_en) begin
            ap_valid_q <= ap_take;
            ap_write_q <= hwrite;
            ap_addr_q  <= {haddr[7:2], 2'h0};
        end
    end

    assign gatp_hit = gatp_blocked(ap_addr_q, priv_mode, tvm_q);
    assign wr_ok    = ap_valid_q && ap_write_q && !gatp_hit;

    // Zero-wait slave, always OKAY
    always_ff @(posedge mclk) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp     <= htgc_pkg::HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= htgc_pkg::HRESP_OKAY;
        end
    end

    // ------------------------------------------------------------------
    // Guest time offset, both halves
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            time_offset_q <= 64'h0;
        end else if (clk_en && wr_ok) begin
            if (ap_addr_q == htgc_pkg::OFF_TDELTA_LO) begin
                time_offset_q[31:0] <= hwdata;
            end
            if (ap_addr_q == htgc_pkg::OFF_TDELTA_HI) begin
                time_offset_q[63:32] <= hwdata;
            end
        end
    end

    // Sum for virtual-mode time reads, carry out dropped
    wire [63:0] vtime = time_offset_q + time_value;

    // ------------------------------------------------------------------
    // Trap value and trap instruction
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            trap_value_q <= 32'h0;
        end else if (clk_en) begin
            if (trap_in.valid) begin
                // Trap logic supplies implicit or portion address
                trap_value_q <= trap_in.guest_fault ? gpa_shift(trap_in.gpa)
                                                    : 32'h0;
            end else if (wr_ok && ap_addr_q == htgc_pkg::OFF_TVAL) begin
                trap_value_q <= hwdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            trap_inst_q <= 32'h0;
        end else if (clk_en) begin
            if (trap_in.valid) begin
                trap_inst_q <= trap_in.inst;
            end else if (wr_ok && ap_addr_q == htgc_pkg::OFF_TINST) begin
                trap_inst_q <= hwdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Guest translation control, fields legalised one by one
    // ------------------------------------------------------------------
    // Only the 32-bit layout is built; the wider layout is left out
    always_ff @(posedge mclk) begin
        if (reset) begin
            scheme_q             <= htgc_pkg::HTGC_BARE;
            machine_identifier_q <= '0;
            root_page_number_q   <= '0;
        end else if (clk_en && wr_ok && ap_addr_q == htgc_pkg::OFF_GATP) begin
            scheme_q             <= hwdata[htgc_pkg::GATP_MODE_POS];
            machine_identifier_q <= hwdata[htgc_pkg::GATP_MID_LO +: MID_W];
            root_page_number_q   <= {hwdata[htgc_pkg::GATP_PPN_HI:htgc_pkg::PPN_ZERO_W],
                                     2'h0};
        end
    end

    // Identifier padded to the full field, unbuilt high bits read zero
    always_comb begin
        mid_read            = '0;
        mid_read[MID_W-1:0] = machine_identifier_q;
    end

    // ------------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            tvm_q <= 1'b0;
            hu_q  <= 1'b0;
        end else if (clk_en && wr_ok && ap_addr_q == htgc_pkg::OFF_CTRL) begin
            tvm_q <= hwdata[htgc_pkg::CTRL_TVM_POS];
            hu_q  <= hwdata[htgc_pkg::CTRL_HU_POS];
        end
    end

    // ------------------------------------------------------------------
    // Translation outputs and illegal access pulse
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            gatp_active_q    <= 1'b0;
            gatp_bare_q      <= 1'b1;
            illegal_access_q <= 1'b0;
        end else if (clk_en) begin
            gatp_active_q    <= !((priv_mode == 3'(htgc_pkg::HTGC_PRIV_U)) && !hu_q);
            gatp_bare_q      <= (scheme_q == htgc_pkg::HTGC_BARE);
            illegal_access_q <= ap_valid_q && gatp_hit;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            hrdata <= 32'h0;
        end else if (clk_en) begin
            hrdata <= 32'h0;
            if (ap_take && !hwrite
                && !gatp_blocked({haddr[7:2], 2'h0}, priv_mode, tvm_q)) begin
                case ({haddr[7:2], 2'h0})
                    htgc_pkg::OFF_TDELTA_LO: hrdata <= time_offset_q[31:0];
                    htgc_pkg::OFF_TDELTA_HI: hrdata <= time_offset_q[63:32];
                    htgc_pkg::OFF_TVAL:      hrdata <= trap_value_q;
                    htgc_pkg::OFF_TINST:     hrdata <= trap_inst_q;
                    htgc_pkg::OFF_GATP:      hrdata <= {scheme_q, 2'h0, mid_read,
                                                        root_page_number_q};
                    htgc_pkg::OFF_STATUS:    hrdata <= {29'h0, illegal_access_q,
                                                        gatp_bare_q, gatp_active_q};
                    htgc_pkg::OFF_VTIME_LO:  hrdata <= vtime[31:0];
                    htgc_pkg::OFF_VTIME_HI:  hrdata <= vtime[63:32];
                    htgc_pkg::OFF_CTRL:      hrdata <= {30'h0, hu_q, tvm_q};
                    default:                 hrdata <= 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_trap_other_clears;
        @(posedge mclk) disable iff (reset)
        (clk_en && trap_in.valid && !trap_in.guest_fault) |=> (trap_value_q == 32'h0);
    endproperty
    a_trap_other_clears: assert property (p_trap_other_clears)
        else $error("trap value not cleared");

    property p_trap_gpa;
        @(posedge mclk) disable iff (reset)
        (clk_en && trap_in.valid && trap_in.guest_fault)
            |=> (trap_value_q == $past(trap_in.gpa[33:2]));
    endproperty
    a_trap_gpa: assert property (p_trap_gpa)
        else $error("trap value not shifted address");

    property p_inst;
        @(posedge mclk) disable iff (reset)
        (clk_en && trap_in.valid) |=> (trap_inst_q == $past(trap_in.inst));
    endproperty
    a_inst: assert property (p_inst)
        else $error("trap instruction not loaded");

    property p_ppn_low;
        @(posedge mclk) disable iff (reset)
        root_page_number_q[1:0] == 2'h0;
    endproperty
    a_ppn_low: assert property (p_ppn_low)
        else $error("root page low bits nonzero");

    property p_tvm_blocks;
        @(posedge mclk) disable iff (reset)
        (clk_en && ap_valid_q && ap_write_q && gatp_hit) |=>
            ($stable(scheme_q) && $stable(root_page_number_q) && illegal_access_q);
    endproperty
    a_tvm_blocks: assert property (p_tvm_blocks)
        else $error("trapped write changed translation control");

    property p_active;
        @(posedge mclk) disable iff (reset)
        (clk_en && priv_mode == 3'(htgc_pkg::HTGC_PRIV_U) && !hu_q) |=> !gatp_active_q;
    endproperty
    a_active: assert property (p_active)
        else $error("translation control active in user mode");

    property p_hi_write;
        @(posedge mclk) disable iff (reset)
        (clk_en && wr_ok && ap_addr_q == htgc_pkg::OFF_TDELTA_HI)
            |=> (time_offset_q[63:32] == $past(hwdata));
    endproperty
    a_hi_write: assert property (p_hi_write)
        else $error("high half not written");

    property p_vtime;
        @(posedge mclk) disable iff (reset)
        (clk_en && ap_take && !hwrite && haddr[7:0] == htgc_pkg::OFF_VTIME_LO)
            |=> (hrdata == 32'($past(time_offset_q) + $past(time_value)));
    endproperty
    a_vtime: assert property (p_vtime)
        else $error("virtual time sum wrong");

    property p_lo_write;
        @(posedge mclk) disable iff (reset)
        (clk_en && wr_ok && ap_addr_q == htgc_pkg::OFF_TDELTA_LO)
            |=> (time_offset_q[31:0] == $past(hwdata));
    endproperty
    a_lo_write: assert property (p_lo_write)
        else $error("low half not written");

    property p_tval_write;
        @(posedge mclk) disable iff (reset)
        (clk_en && wr_ok && !trap_in.valid && ap_addr_q == htgc_pkg::OFF_TVAL)
            |=> (trap_value_q == $past(hwdata));
    endproperty
    a_tval_write: assert property (p_tval_write)
        else $error("trap value write not retained");

    property p_mid_write;
        @(posedge mclk) disable iff (reset)
        (clk_en && wr_ok && ap_addr_q == htgc_pkg::OFF_GATP)
            |=> (machine_identifier_q == $past(hwdata[htgc_pkg::GATP_MID_LO +: MID_W]));
    endproperty
    a_mid_write: assert property (p_mid_write)
        else $error("identifier low bits not written");

    property p_bare;
        @(posedge mclk) disable iff (reset)
        clk_en |=> (gatp_bare_q == ($past(scheme_q) == htgc_pkg::HTGC_BARE));
    endproperty
    a_bare: assert property (p_bare)
        else $error("bare flag does not follow scheme");

    // Blocked access in its data phase
    sequence s_blocked_access;
        clk_en && ap_valid_q && gatp_hit;
    endsequence

    property p_illegal_pulse;
        @(posedge mclk) disable iff (reset)
        s_blocked_access |=> illegal_access_q;
    endproperty
    a_illegal_pulse: assert property (p_illegal_pulse)
        else $error("blocked access raised no illegal pulse");

    property p_blocked_read;
        @(posedge mclk) disable iff (reset)
        (clk_en && ap_take && !hwrite && gatp_blocked({haddr[7:2], 2'h0}, priv_mode, tvm_q))
            |=> (hrdata == 32'h0);
    endproperty
    a_blocked_read: assert property (p_blocked_read)
        else $error("blocked read returned data");

endmodule

// ---- htgc_pkg.sv ----
package htgc_pkg;

    // ------------------------------------------------------------------
    // Register map (word aligned byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_TDELTA_LO = 8'h00;
    localparam logic [7:0] OFF_TDELTA_HI = 8'h04;
    localparam logic [7:0] OFF_TVAL      = 8'h08;
    localparam logic [7:0] OFF_TINST     = 8'h0C;
    localparam logic [7:0] OFF_GATP      = 8'h10;
    localparam logic [7:0] OFF_STATUS    = 8'h14;
    localparam logic [7:0] OFF_VTIME_LO  = 8'h18;
    localparam logic [7:0] OFF_VTIME_HI  = 8'h1C;
    localparam logic [7:0] OFF_CTRL      = 8'h20;

    // ------------------------------------------------------------------
    // Guest translation control layout (32-bit hypervisor width)
    // ------------------------------------------------------------------
    localparam int GATP_MODE_POS = 31;
    localparam int GATP_ZERO_HI  = 30;
    localparam int GATP_ZERO_LO  = 29;
    localparam int GATP_MID_HI   = 28;
    localparam int GATP_MID_LO   = 22;
    localparam int GATP_PPN_HI   = 21;
    localparam int GATP_PPN_W    = 22;
    localparam int MID_W_MAX     = 7;
    localparam int PPN_ZERO_W    = 2;
    localparam int GPA_SHIFT     = 2;
    localparam int GPA_W         = 34;

    // Control register bits
    localparam int CTRL_TVM_POS  = 0;
    localparam int CTRL_HU_POS   = 1;

    // Scheme field encodings
    typedef enum logic {
        HTGC_BARE   = 1'b0,
        HTGC_PAGED  = 1'b1
    } htgc_scheme_e;

    // Privilege encodings seen from the hart
    typedef enum logic [2:0] {
        HTGC_PRIV_U,
        HTGC_PRIV_S,
        HTGC_PRIV_M,
        HTGC_PRIV_VU,
        HTGC_PRIV_VS
    } htgc_priv_e;

    // Trap report from the trap logic
    typedef struct packed {
        logic             valid;
        logic             guest_fault;
        logic [GPA_W-1:0] gpa;
        logic [31:0]      inst;
    } htgc_trap_s;

    localparam logic [1:0] HRESP_OKAY = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ---- tb_hyp_time_trap_gstage_csrs.sv ----
`timescale 1ns/1ps
module tb_hyp_time_trap_gstage_csrs;
    // ------------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------------
    localparam int          mid_w = 5;
    localparam logic [31:0] gmask = 32'h803F_FFFC | (((32'h1 << mid_w) - 32'h1) << 22);
    logic                   mclk = 1'b0;
    logic                   reset = 1'b1;
    logic                   clk_en = 1'b1;
    logic                   hsel = 1'b0;
    logic                   hwrite = 1'b0;
    logic [31:0]            haddr = 32'h0;
    logic [1:0]             htrans = 2'h0;
    logic [2:0]             hsize = 3'h2;
    logic [31:0]            hwdata = 32'h0;
    logic [31:0]            hrdata;
    logic                   hreadyout;
    logic [1:0]             hresp;
    logic [63:0]            time_value = 64'h0;
    logic [2:0]             priv_mode = htgc_pkg::HTGC_PRIV_S;
    htgc_pkg::htgc_trap_s   trap_in = '0;
    logic                   gatp_active_q;
    logic                   gatp_bare_q;
    logic [mid_w-1:0]       machine_identifier_q;
    logic [21:0]            root_page_number_q;
    logic                   illegal_access_q;
    logic [31:0]            lfsr = 32'hD746;
    logic [31:0]            mdl [0:8];
    logic [31:0]            rd;
    int                     failures = 0;
    int                     compares = 0;
    int                     ill_cnt = 0;
    int                     ill_exp = 0;

    // Clock at 25 ns
    always #12.5 mclk = ~mclk;

    htgc_csrs #(.MID_W(mid_w)) DUT (
        .mclk(mclk), .reset(reset), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .time_value(time_value), .priv_mode(priv_mode), .trap_in(trap_in),
        .gatp_active_q(gatp_active_q), .gatp_bare_q(gatp_bare_q),
        .machine_identifier_q(machine_identifier_q),
        .root_page_number_q(root_page_number_q), .illegal_access_q(illegal_access_q));

    // Counts refused-access pulses
    always @(posedge mclk) begin
        if (illegal_access_q === 1'b1) ill_cnt <= ill_cnt + 1;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd32();
        repeat (32) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    function automatic logic blocked();
        return mdl[8][0] && priv_mode == htgc_pkg::HTGC_PRIV_S;
    endfunction

    // Expected read value from the model
    function automatic logic [31:0] mexp(input logic [7:0] a);
        logic [63:0] vt;
        vt = {mdl[1], mdl[0]} + time_value;
        case (a)
            8'h00, 8'h04, 8'h08, 8'h0C: mexp = mdl[a[5:2]];
            8'h10: mexp = blocked() ? 32'h0 : mdl[4];
            8'h18: mexp = vt[31:0];
            8'h1C: mexp = vt[63:32];
            8'h20: mexp = mdl[8];
            default: mexp = 32'h0;
        endcase
    endfunction

    task automatic conclude();
        if (failures == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One AHB-Lite single word transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] r);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= htgc_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        r = hrdata;
        check(hresp, htgc_pkg::HRESP_OKAY);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
        if (a == htgc_pkg::OFF_GATP && blocked()) ill_exp++;
        else if (a == htgc_pkg::OFF_GATP) mdl[4] = d & gmask;
        else if (a == htgc_pkg::OFF_CTRL) mdl[8] = d & 32'h3;
        else if (a <= htgc_pkg::OFF_TINST) mdl[a[5:2]] = d;
    endtask

    task automatic rc(input logic [7:0] a);
        bus(1'b0, a, rnd32(), rd);
        if (a == htgc_pkg::OFF_GATP && blocked()) ill_exp++;
        check(rd, mexp(a));
    endtask

    task automatic trap(input logic gf, input logic [33:0] gpa, input logic [31:0] ins);
        @(posedge mclk);
        trap_in <= {1'b1, gf, gpa, ins};
        @(posedge mclk);
        trap_in <= '0;
        mdl[2] = gf ? gpa[33:2] : 32'h0;
        mdl[3] = ins;
    endtask

    task automatic outs();
        repeat (2) @(posedge mclk);
        #1;
        check(gatp_bare_q, !mdl[4][31]);
        check(machine_identifier_q, mdl[4][22 +: mid_w]);
        check(root_page_number_q, mdl[4][21:0]);
    endtask

    // Watchdog
    initial begin
        repeat (6000) @(posedge mclk);
        failures++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        for (int i = 0; i < 9; i++) mdl[i] = 32'h0;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 5; i++) rc(8'(4 * i));
        bus(1'b0, htgc_pkg::OFF_STATUS, 32'h0, rd);
        check(rd[2:0], 3'h3);
        // Virtual time sum with carry dropped
        for (int i = 0; i < 4; i++) begin
            priv_mode <= i[1] ? htgc_pkg::HTGC_PRIV_VU : htgc_pkg::HTGC_PRIV_VS;
            time_value <= {rnd32(), rnd32()};
            wr(htgc_pkg::OFF_TDELTA_LO, rnd32());
            wr(htgc_pkg::OFF_TDELTA_HI, i[0] ? 32'hFFFF_FFFF : rnd32());
            rc(htgc_pkg::OFF_TDELTA_HI);
            rc(htgc_pkg::OFF_VTIME_LO);
            rc(htgc_pkg::OFF_VTIME_HI);
        end
        // Trap value and trap instruction
        for (int i = 0; i < 4; i++) begin
            wr(htgc_pkg::OFF_TVAL, rnd32());
            rc(htgc_pkg::OFF_TVAL);
            wr(htgc_pkg::OFF_TINST, rnd32());
            rc(htgc_pkg::OFF_TINST);
            trap(i[0], 34'({rnd32(), rnd32()}), rnd32());
            rc(htgc_pkg::OFF_TVAL);
            rc(htgc_pkg::OFF_TINST);
        end
        // Clock enable low: a trap pulse must leave both registers frozen
        @(posedge mclk);
        clk_en <= 1'b0;
        trap_in <= {2'b11, 34'h3_0000_0004, 32'h0000_0001};
        @(posedge mclk);
        clk_en <= 1'b1;
        trap_in <= '0;
        rc(htgc_pkg::OFF_TVAL);
        rc(htgc_pkg::OFF_TINST);
        // Translation control fields
        wr(htgc_pkg::OFF_GATP, 32'hFFFF_FFFF);
        rc(htgc_pkg::OFF_GATP);
        outs();
        for (int i = 0; i < 4; i++) begin
            wr(htgc_pkg::OFF_GATP, rnd32() | 32'h8000_0000);
            rc(htgc_pkg::OFF_GATP);
            outs();
        end
        wr(htgc_pkg::OFF_GATP, 32'h0);
        rc(htgc_pkg::OFF_GATP);
        outs();
        // Refused access under the trap flag, from supervisor mode
        priv_mode <= htgc_pkg::HTGC_PRIV_S;
        wr(htgc_pkg::OFF_GATP, 32'h8040_0104);
        wr(htgc_pkg::OFF_CTRL, 32'h1);
        wr(htgc_pkg::OFF_GATP, 32'hFFFF_FFFF);
        rc(htgc_pkg::OFF_GATP);
        priv_mode <= htgc_pkg::HTGC_PRIV_M;
        rc(htgc_pkg::OFF_GATP);
        repeat (3) @(posedge mclk);
        check(ill_cnt, ill_exp);
        // Active flag against privilege and user-access flag
        for (int k = 0; k < 4; k++) begin
            priv_mode <= k[1] ? htgc_pkg::HTGC_PRIV_S : htgc_pkg::HTGC_PRIV_U;
            wr(htgc_pkg::OFF_CTRL, {30'h0, k[0], 1'b0});
            repeat (2) @(posedge mclk);
            #1;
            check(gatp_active_q, k[1] | k[0]);
            rc(htgc_pkg::OFF_CTRL);
        end
        // Unmapped place
        wr(8'h24, rnd32());
        rc(8'h24);
        rc(8'h28);
        conclude();
    end
endmodule
